/* File: pkg/pcrai_cfg.svh */
/*
 * Offsets, field positions, reset values and timing counts of the
 * precision-time clock core. Assumes byte addresses on a 12-bit register port.
 */
`ifndef PCRAI_CFG_SVH
`define PCRAI_CFG_SVH

// ******************************************************************
// Register offsets
// ******************************************************************
`define PCRAI_OFS_CLR_CTL 12'h104
`define PCRAI_OFS_IRQ_STATUS 12'h108
`define PCRAI_OFS_IRQ_ENABLE 12'h10C
`define PCRAI_OFS_TIME_SEC 12'h110
`define PCRAI_OFS_TIME_NS 12'h114
`define PCRAI_OFS_TIME_FRAC 12'h118
`define PCRAI_OFS_RATE_TRIM 12'h11C
`define PCRAI_OFS_TGT_A_SEC 12'h12C
`define PCRAI_OFS_TGT_A_NS 12'h130
`define PCRAI_OFS_TGT_B_SEC 12'h13C
`define PCRAI_OFS_TGT_B_NS 12'h140

// ******************************************************************
// Field positions and masks
// ******************************************************************
`define PCRAI_BIT_TIMER_A 0
`define PCRAI_BIT_TIMER_B 1
`define PCRAI_MSK_IRQ 32'hFFFF_7703
`define PCRAI_MSK_NS 32'h3FFF_FFFF
`define PCRAI_MSK_TRIM 32'hBFFF_FFFF
`define PCRAI_MSK_CLR_CTL 32'h0000_1F1F
`define PCRAI_BIT_TRIM_DIR 31
`define PCRAI_RST_WORD 32'h0000_0000

// ******************************************************************
// Timing
// ******************************************************************
`define PCRAI_CLK_PERIOD_NS 40
`define PCRAI_GPIO_MIN_NS 40
`define PCRAI_GPIO_MIN_CYC ((`PCRAI_GPIO_MIN_NS / `PCRAI_CLK_PERIOD_NS) + 1)
`define PCRAI_STEP_NOMINAL_NS 4'hA
`define PCRAI_STEP_SLOW_NS 4'h9
`define PCRAI_STEP_FAST_NS 4'hB
`define PCRAI_NS_PER_SEC 30'h3B9A_CA00

`endif

/* File: pkg/pcrai_pkg.sv */
/*
 * Types of the precision-time clock core.
 * Assumes the constants header is compiled alongside.
 */
`default_nettype none
package pcrai_pkg;
  typedef logic [31:0] pcrai_word_t;
  typedef logic [29:0] pcrai_ns_t;
  typedef logic [11:0] pcrai_addr_t;
  typedef enum logic {
    PCRAI_DIR_SLOWER = 1'b0,
    PCRAI_DIR_FASTER = 1'b1
  } pcrai_dir_t;
endpackage
`default_nettype wire

/* File: core/pcrai_core.sv */
/*
 * Precision-time clock core: running time, rate trim, two target compare
 * channels, interrupt status/enable and GPIO edge filtering.
 * Assumes one reference clock, synchronous inputs, and single-cycle command
 * strobes from an external command register.
 */
// Overview of operation
// - Set timer B flag when time reaches target
// - Set timer A flag when time reaches target
// - Filtered GPIO edge clears enabled timer flags
// - Status bits clear on write of one
// - OR enabled status bits into aggregate event
// - Status records events regardless of enable
// - System request needs event and global enable
// - GPIO edge enables in bits 31:16
// - Timestamp enables 14:12, 10:8; reserved read zero
// - Timer enables in bits 1 and 0
// - Time reads return snapshot from read command
// - Load command replaces running time
// - Seconds field full 32 bits, reset zero
// - Nanoseconds bits 29:0, upper bits reserved
// - Fraction field full 32 bits, reset zero
// - Nominal advance of ten nanoseconds per cycle
// - Trim direction picks nine or eleven
// - Trim amount accumulates into fraction each cycle
// - Fraction wrap applies one nanosecond correction
`timescale 1ns/100ps
`default_nettype none
`include "pcrai_cfg.svh"

module pcrai_core (
  input wire logic i_ref_clk, // reference clock
  input wire logic i_resetn, // asynchronous reset, active low
  input wire pcrai_pkg::pcrai_addr_t i_addr, // register byte address
  input wire pcrai_pkg::pcrai_word_t i_wdata, // write data
  input wire logic i_wr, // write strobe
  input wire logic i_rd, // read strobe
  output pcrai_pkg::pcrai_word_t o_rdata, // read data, cycle after strobe
  input wire logic i_time_read_cmd, // snapshot strobe
  input wire logic i_time_load_cmd, // load strobe
  input wire logic [7:0] i_gpio, // GPIO levels
  input wire logic [2:0] i_ingress_stamp_evt, // per-port ingress stamp pulse
  input wire logic [2:0] i_egress_stamp_evt, // per-port egress stamp pulse
  input wire logic i_ptp_aggregate_event_enable, // global event enable
  output logic o_ptp_aggregate_event, // aggregated status event
  output logic o_sys_irq, // system interrupt request
  output pcrai_pkg::pcrai_word_t o_run_seconds, // live seconds
  output pcrai_pkg::pcrai_ns_t o_run_nanoseconds, // live nanoseconds
  output pcrai_pkg::pcrai_word_t o_run_fraction // live fraction
);
  import pcrai_pkg::*;

  // ******************************************************************
  // Helpers
  // ******************************************************************
  function automatic logic time_ge(input pcrai_word_t s, input pcrai_ns_t n,
                                   input pcrai_word_t ts, input pcrai_ns_t tn);
    time_ge = (s > ts) || ((s == ts) && (n >= tn));
  endfunction

  function automatic logic wr_hit(input pcrai_addr_t a, input logic w, input pcrai_addr_t ofs);
    wr_hit = w && (a == ofs);
  endfunction

  // ******************************************************************
  // Registers
  // ******************************************************************
  pcrai_word_t irq_status;
  pcrai_word_t ptp_irq_enable;
  pcrai_word_t time_seconds;
  pcrai_ns_t time_nanoseconds;
  pcrai_word_t time_fraction;
  pcrai_dir_t rate_trim_direction;
  pcrai_ns_t rate_trim_amount;
  pcrai_word_t target_seconds_a;
  pcrai_ns_t target_nanoseconds_a;
  pcrai_word_t target_seconds_b;
  pcrai_ns_t target_nanoseconds_b;
  logic [12:0] clr_ctl;
  pcrai_word_t run_sec;
  pcrai_ns_t run_ns;
  pcrai_word_t run_frac;

  // ******************************************************************
  // Register writes and time snapshot
  // ******************************************************************
  // enable register
  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      ptp_irq_enable <= `PCRAI_RST_WORD;
    end else if (wr_hit(i_addr, i_wr, `PCRAI_OFS_IRQ_ENABLE)) begin
      ptp_irq_enable <= i_wdata & `PCRAI_MSK_IRQ;
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      rate_trim_direction <= PCRAI_DIR_SLOWER;
      rate_trim_amount <= 30'h0000_0000;
      clr_ctl <= 13'h0000;
    end else begin
      if (wr_hit(i_addr, i_wr, `PCRAI_OFS_RATE_TRIM)) begin
        rate_trim_direction <= pcrai_dir_t'(i_wdata[`PCRAI_BIT_TRIM_DIR]);
        rate_trim_amount <= i_wdata[29:0];
      end
      if (wr_hit(i_addr, i_wr, `PCRAI_OFS_CLR_CTL)) begin
        clr_ctl <= i_wdata[12:0] & 13'h1F1F;
      end
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      target_seconds_a <= `PCRAI_RST_WORD;
      target_nanoseconds_a <= 30'h0000_0000;
      target_seconds_b <= `PCRAI_RST_WORD;
      target_nanoseconds_b <= 30'h0000_0000;
    end else begin
      if (wr_hit(i_addr, i_wr, `PCRAI_OFS_TGT_A_SEC)) begin
        target_seconds_a <= i_wdata;
      end
      if (wr_hit(i_addr, i_wr, `PCRAI_OFS_TGT_A_NS)) begin
        target_nanoseconds_a <= i_wdata[29:0];
      end
      if (wr_hit(i_addr, i_wr, `PCRAI_OFS_TGT_B_SEC)) begin
        target_seconds_b <= i_wdata;
      end
      if (wr_hit(i_addr, i_wr, `PCRAI_OFS_TGT_B_NS)) begin
        target_nanoseconds_b <= i_wdata[29:0];
      end
    end
  end

  // The snapshot shares storage with the load values, so a read command
  // between writing the load values and loading them overwrites them.
  // snapshot and software values
  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      time_seconds <= `PCRAI_RST_WORD;
      time_nanoseconds <= 30'h0000_0000;
      time_fraction <= `PCRAI_RST_WORD;
    end else if (i_time_read_cmd) begin
      time_seconds <= run_sec;
      time_nanoseconds <= run_ns;
      time_fraction <= run_frac;
    end else begin
      if (wr_hit(i_addr, i_wr, `PCRAI_OFS_TIME_SEC)) begin
        time_seconds <= i_wdata;
      end
      if (wr_hit(i_addr, i_wr, `PCRAI_OFS_TIME_NS)) begin
        time_nanoseconds <= i_wdata[29:0];
      end
      if (wr_hit(i_addr, i_wr, `PCRAI_OFS_TIME_FRAC)) begin
        time_fraction <= i_wdata;
      end
    end
  end

  // ******************************************************************
  // Running time
  // ******************************************************************
  logic [32:0] frac_sum;
  logic frac_wrap;
  logic [3:0] step_ns;
  logic [30:0] ns_sum;
  logic ns_over;

  assign frac_sum = {1'b0, run_frac} + {3'b000, rate_trim_amount};
  assign frac_wrap = frac_sum[32];

  always_comb begin
    if (!frac_wrap) begin
      step_ns = `PCRAI_STEP_NOMINAL_NS;
    end else if (rate_trim_direction == PCRAI_DIR_FASTER) begin
      step_ns = `PCRAI_STEP_FAST_NS;
    end else begin
      step_ns = `PCRAI_STEP_SLOW_NS;
    end
  end

  assign ns_sum = {1'b0, run_ns} + {27'h000_0000, step_ns};
  assign ns_over = ns_sum >= {1'b0, `PCRAI_NS_PER_SEC};

  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      run_sec <= `PCRAI_RST_WORD;
      run_ns <= 30'h0000_0000;
      run_frac <= `PCRAI_RST_WORD;
    end else if (i_time_load_cmd) begin
      run_sec <= time_seconds;
      run_ns <= time_nanoseconds;
      run_frac <= time_fraction;
    end else begin
      run_frac <= frac_sum[31:0];
      if (ns_over) begin
        run_ns <= 30'(ns_sum - {1'b0, `PCRAI_NS_PER_SEC});
        run_sec <= run_sec + 32'h0000_0001;
      end else begin
        run_ns <= ns_sum[29:0];
      end
    end
  end

  assign o_run_seconds = run_sec;
  assign o_run_nanoseconds = run_ns;
  assign o_run_fraction = run_frac;

  // ******************************************************************
  // GPIO edge filter
  // ******************************************************************
  // A level change counts only after it has held for more than the minimum
  // active time, so short glitches never clear a flag.
  logic [7:0] gpio_filt;
  logic [1:0] gpio_cnt [8];
  logic [7:0] gpio_rise;
  logic [7:0] gpio_fall;

  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      gpio_filt <= 8'h00;
      gpio_rise <= 8'h00;
      gpio_fall <= 8'h00;
      for (int i = 0; i < 8; i++) begin
        gpio_cnt[i] <= 2'h0;
      end
    end else begin
      for (int i = 0; i < 8; i++) begin
        gpio_rise[i] <= 1'b0;
        gpio_fall[i] <= 1'b0;
        if (i_gpio[i] == gpio_filt[i]) begin
          gpio_cnt[i] <= 2'h0;
        end else if (gpio_cnt[i] == 2'(`PCRAI_GPIO_MIN_CYC - 1)) begin
          gpio_cnt[i] <= 2'h0;
          gpio_filt[i] <= i_gpio[i];
          gpio_rise[i] <= i_gpio[i];
          gpio_fall[i] <= !i_gpio[i];
        end else begin
          gpio_cnt[i] <= gpio_cnt[i] + 2'h1;
        end
      end
    end
  end

  // ******************************************************************
  // Compare, status and event
  // ******************************************************************
  logic cmp_a;
  logic cmp_b;
  logic cmp_a_q;
  logic cmp_b_q;
  logic set_a;
  logic set_b;
  logic gpio_clr_a;
  logic gpio_clr_b;
  pcrai_word_t set_vec;
  pcrai_word_t clr_vec;

  assign cmp_a = time_ge(run_sec, run_ns, target_seconds_a, target_nanoseconds_a);
  assign cmp_b = time_ge(run_sec, run_ns, target_seconds_b, target_nanoseconds_b);

  // Held high at reset so a zero target does not fire right after reset.
  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      cmp_a_q <= 1'b1;
      cmp_b_q <= 1'b1;
    end else begin
      cmp_a_q <= cmp_a;
      cmp_b_q <= cmp_b;
    end
  end

  assign set_a = cmp_a && !cmp_a_q;
  assign set_b = cmp_b && !cmp_b_q;

  assign gpio_clr_a = clr_ctl[4] &&
    (clr_ctl[3] ? gpio_rise[clr_ctl[2:0]] : gpio_fall[clr_ctl[2:0]]);
  assign gpio_clr_b = clr_ctl[12] &&
    (clr_ctl[11] ? gpio_rise[clr_ctl[10:8]] : gpio_fall[clr_ctl[10:8]]);

  assign set_vec = {gpio_fall, gpio_rise, 1'b0, i_egress_stamp_evt, 1'b0,
                    i_ingress_stamp_evt, 6'h00, set_b, set_a};
  assign clr_vec = (wr_hit(i_addr, i_wr, `PCRAI_OFS_IRQ_STATUS) ? i_wdata : 32'h0000_0000) |
                   {30'h0000_0000, gpio_clr_b, gpio_clr_a};

  // A set in the same cycle as a clear wins, so no event is lost.
  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      irq_status <= `PCRAI_RST_WORD;
    end else begin
      irq_status <= ((irq_status & ~clr_vec) | set_vec) & `PCRAI_MSK_IRQ;
    end
  end

  assign o_ptp_aggregate_event = |(irq_status & ptp_irq_enable);
  assign o_sys_irq = o_ptp_aggregate_event && i_ptp_aggregate_event_enable;

  // ******************************************************************
  // Read port
  // ******************************************************************
  pcrai_word_t next_rdata;

  always_comb begin
    next_rdata = 32'h0000_0000;
    if (i_rd) begin
      case (i_addr)
        `PCRAI_OFS_CLR_CTL: next_rdata = {19'h0_0000, clr_ctl};
        `PCRAI_OFS_IRQ_STATUS: next_rdata = irq_status;
        `PCRAI_OFS_IRQ_ENABLE: next_rdata = ptp_irq_enable;
        `PCRAI_OFS_TIME_SEC: next_rdata = time_seconds;
        `PCRAI_OFS_TIME_NS: next_rdata = {2'b00, time_nanoseconds};
        `PCRAI_OFS_TIME_FRAC: next_rdata = time_fraction;
        `PCRAI_OFS_RATE_TRIM: next_rdata = {rate_trim_direction, 1'b0, rate_trim_amount};
        `PCRAI_OFS_TGT_A_SEC: next_rdata = target_seconds_a;
        `PCRAI_OFS_TGT_A_NS: next_rdata = {2'b00, target_nanoseconds_a};
        `PCRAI_OFS_TGT_B_SEC: next_rdata = target_seconds_b;
        `PCRAI_OFS_TGT_B_NS: next_rdata = {2'b00, target_nanoseconds_b};
        default: next_rdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_rdata <= 32'h0000_0000;
    end else begin
      o_rdata <= next_rdata;
    end
  end

  // ******************************************************************
  // Assertions
  // ******************************************************************
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_resetn);

  sequence s_reach_b;
    cmp_b && !cmp_b_q;
  endsequence
  sequence s_flag_b_up;
    irq_status[`PCRAI_BIT_TIMER_B] [*2];
  endsequence

  property p_timer_b_set;
    s_reach_b |=> s_flag_b_up or (irq_status[`PCRAI_BIT_TIMER_B] ##1 $fell(irq_status[1]));
  endproperty
  a_timer_b_set: assert property (p_timer_b_set) else $error("timer B flag not set");

  property p_timer_a_set;
    set_a |=> irq_status[`PCRAI_BIT_TIMER_A];
  endproperty
  a_timer_a_set: assert property (p_timer_a_set) else $error("timer A flag not set");

  property p_gpio_clear;
    gpio_clr_a && !set_a |=> !irq_status[`PCRAI_BIT_TIMER_A];
  endproperty
  a_gpio_clear: assert property (p_gpio_clear) else $error("GPIO edge did not clear A");

  property p_glitch_ignored;
    !$changed(i_gpio[0]) ##1 $changed(i_gpio[0]) ##1 $changed(i_gpio[0]) |=> !gpio_rise[0] && !gpio_fall[0];
  endproperty
  a_glitch_ignored: assert property (p_glitch_ignored) else $error("one-cycle GPIO pulse seen");

  property p_w1c_keep;
    i_wr && i_addr == `PCRAI_OFS_IRQ_STATUS && !i_wdata[0] && irq_status[0] && !gpio_clr_a
      |=> irq_status[0];
  endproperty
  a_w1c_keep: assert property (p_w1c_keep) else $error("zero write cleared status");

  property p_w1c_clear;
    i_wr && i_addr == `PCRAI_OFS_IRQ_STATUS && i_wdata[1] && !set_b |=> !irq_status[1];
  endproperty
  a_w1c_clear: assert property (p_w1c_clear) else $error("one write did not clear");

  property p_event_gate;
    irq_status[0] && ptp_irq_enable[0] |-> o_ptp_aggregate_event;
  endproperty
  a_event_gate: assert property (p_event_gate) else $error("enabled status missing from event");

  property p_sys_irq;
    o_sys_irq |-> o_ptp_aggregate_event && i_ptp_aggregate_event_enable;
  endproperty
  a_sys_irq: assert property (p_sys_irq) else $error("system request without both enables");

  property p_enable_reserved;
    i_rd && i_addr == `PCRAI_OFS_IRQ_ENABLE |=> (o_rdata & ~`PCRAI_MSK_IRQ) == 32'h0000_0000;
  endproperty
  a_enable_reserved: assert property (p_enable_reserved) else $error("reserved enable bits set");

  property p_snapshot;
    i_time_read_cmd |=> time_seconds == $past(run_sec) && time_nanoseconds == $past(run_ns);
  endproperty
  a_snapshot: assert property (p_snapshot) else $error("snapshot mismatch");

  property p_load;
    i_time_load_cmd |=> run_sec == $past(time_seconds) && run_frac == $past(time_fraction);
  endproperty
  a_load: assert property (p_load) else $error("load did not take");

  property p_nominal_step;
    !i_time_load_cmd && rate_trim_amount == 30'h0000_0000 && run_ns < 30'd999_999_980
      |=> run_ns == $past(run_ns) + 30'd10;
  endproperty
  a_nominal_step: assert property (p_nominal_step) else $error("nominal step not ten");

  property p_trim_step;
    !i_time_load_cmd && frac_wrap && run_ns < 30'd999_999_980
      |=> run_ns == $past(run_ns) + ($past(rate_trim_direction) ? 30'd11 : 30'd9);
  endproperty
  a_trim_step: assert property (p_trim_step) else $error("trim step wrong");

  property p_ns_range;
    !i_time_load_cmd |=> run_ns < `PCRAI_NS_PER_SEC || $past(run_ns) >= `PCRAI_NS_PER_SEC;
  endproperty
  a_ns_range: assert property (p_ns_range) else $error("nanoseconds overflowed");

endmodule
`default_nettype wire

/* File: verif/tb.sv */
/*
 * Self-checking bench of the precision-time clock core: registers, time
 * advance with rate trim, snapshot, load, timer flags, GPIO clear, events.
 * Assumes the core carries its own assertions and the constants header is
 * on the include path.
 */
`timescale 1ns/100ps
`default_nettype none
`include "pcrai_cfg.svh"

module tb;
  import pcrai_pkg::*;

  logic clk = 1'b0;
  logic resetn = 1'b0;
  pcrai_addr_t addr = 12'h000;
  pcrai_word_t wdata = 32'h0000_0000;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic trc = 1'b0;
  logic tlc = 1'b0;
  logic [7:0] gpio = 8'h00;
  logic [2:0] ing = 3'h0;
  logic [2:0] egr = 3'h0;
  logic gen = 1'b0;
  pcrai_word_t rdata;
  pcrai_word_t rsec;
  pcrai_word_t rfrac;
  pcrai_ns_t rns;
  logic ev;
  logic irq;
  integer seed = 32'h16ae;
  integer errors = 0;
  integer tests_run = 0;
  pcrai_word_t ms, mf, trim, v, ex;
  pcrai_ns_t mn;
  logic [2:0] pi, pe;
  pcrai_addr_t ofs [5] = '{`PCRAI_OFS_IRQ_ENABLE, `PCRAI_OFS_TIME_SEC, `PCRAI_OFS_TIME_NS,
                           `PCRAI_OFS_TIME_FRAC, `PCRAI_OFS_RATE_TRIM};
  pcrai_word_t msk [5] = '{`PCRAI_MSK_IRQ, 32'hFFFF_FFFF, `PCRAI_MSK_NS, 32'hFFFF_FFFF,
                           `PCRAI_MSK_TRIM};
  pcrai_word_t tr [4] = '{32'h0000_0000, 32'h3FFF_FFFF, 32'hBFFF_FFFF, 32'h0000_0000};

  pcrai_core i_dut (
    .i_ref_clk(clk), .i_resetn(resetn), .i_addr(addr), .i_wdata(wdata),
    .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .i_time_read_cmd(trc),
    .i_time_load_cmd(tlc), .i_gpio(gpio), .i_ingress_stamp_evt(ing),
    .i_egress_stamp_evt(egr), .i_ptp_aggregate_event_enable(gen),
    .o_ptp_aggregate_event(ev), .o_sys_irq(irq), .o_run_seconds(rsec),
    .o_run_nanoseconds(rns), .o_run_fraction(rfrac)
  );

  always #20 clk = ~clk;

  // ******************************************************************
  // Bus tasks and expectation functions
  // ******************************************************************
  task automatic chk(input pcrai_word_t got, input pcrai_word_t exp);
    tests_run++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic wr32(input pcrai_addr_t a, input pcrai_word_t d);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    // Let one edge pass so a following write never raises the strobe in the same step.
    @(posedge clk);
  endtask

  // Read data stand only in the cycle after the strobe, so sample mid-cycle.
  task automatic rd32(input pcrai_addr_t a, input pcrai_word_t exp);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    chk(rdata, exp);
    @(posedge clk);
  endtask

  function automatic void step(inout pcrai_word_t s, inout pcrai_ns_t n,
                               inout pcrai_word_t f, input pcrai_word_t t);
    logic [32:0] acc;
    logic [30:0] sum;
    acc = {1'b0, f} + {3'b000, t[29:0]};
    f = acc[31:0];
    if (!acc[32]) begin
      sum = {1'b0, n} + {27'h000_0000, `PCRAI_STEP_NOMINAL_NS};
    end else if (t[`PCRAI_BIT_TRIM_DIR]) begin
      sum = {1'b0, n} + {27'h000_0000, `PCRAI_STEP_FAST_NS};
    end else begin
      sum = {1'b0, n} + {27'h000_0000, `PCRAI_STEP_SLOW_NS};
    end
    if (sum >= {1'b0, `PCRAI_NS_PER_SEC}) begin
      sum = sum - {1'b0, `PCRAI_NS_PER_SEC};
      s = s + 32'h0000_0001;
    end
    n = sum[29:0];
  endfunction

  // Ends at a falling edge with the model holding the loaded time.
  task automatic load(input pcrai_word_t s, input pcrai_ns_t n, input pcrai_word_t f);
    wr32(`PCRAI_OFS_TIME_SEC, s);
    wr32(`PCRAI_OFS_TIME_NS, {2'b11, n});
    wr32(`PCRAI_OFS_TIME_FRAC, f);
    tlc <= 1'b1;
    @(posedge clk);
    tlc <= 1'b0;
    ms = s;
    mn = n;
    mf = f;
    @(negedge clk);
    chk(rsec, ms);
    chk({2'b00, rns}, {2'b00, mn});
    chk(rfrac, mf);
  endtask

  task automatic track(input int cycles);
    repeat (cycles) begin
      step(ms, mn, mf, trim);
      @(negedge clk);
      chk(rsec, ms);
      chk({2'b00, rns}, {2'b00, mn});
      chk(rfrac, mf);
    end
    @(posedge clk);
  endtask

  task automatic test_done;
    $display("comparisons %0d, mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // ******************************************************************
  // Main sequence
  // ******************************************************************
  initial begin
    repeat (20) @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
    for (int i = 0; i < 5; i++) begin
      rd32(ofs[i], `PCRAI_RST_WORD);
    end
    rd32(`PCRAI_OFS_IRQ_STATUS, `PCRAI_RST_WORD);
    rd32(12'h000, `PCRAI_RST_WORD);
    $display("test end: reset values");
    for (int k = 0; k < 4; k++) begin
      for (int i = 0; i < 5; i++) begin
        v = $random(seed);
        wr32(ofs[i], v);
        rd32(ofs[i], v & msk[i]);
      end
    end
    wr32(`PCRAI_OFS_IRQ_ENABLE, 32'h0000_0000);
    $display("test end: register access");
    for (int i = 0; i < 4; i++) begin
      trim = (i == 3) ? $random(seed) : tr[i];
      wr32(`PCRAI_OFS_RATE_TRIM, trim);
      load($random(seed), `PCRAI_NS_PER_SEC - 30'h0000_0064, $random(seed));
      track(40);
    end
    $display("test end: time advance");
    // The snapshot holds the time seen in the cycle of the command edge.
    trc <= 1'b1;
    step(ms, mn, mf, trim);
    @(posedge clk);
    trc <= 1'b0;
    repeat (3) @(posedge clk);
    rd32(`PCRAI_OFS_TIME_SEC, ms);
    rd32(`PCRAI_OFS_TIME_NS, {2'b00, mn});
    rd32(`PCRAI_OFS_TIME_FRAC, mf);
    $display("test end: snapshot");
    trim = 32'h0000_0000;
    wr32(`PCRAI_OFS_RATE_TRIM, trim);
    for (int ch = 0; ch < 2; ch++) begin
      gen <= 1'b1;
      load(32'h0000_0007, 30'h0000_0000, 32'h0000_0000);
      @(posedge clk);
      wr32(`PCRAI_OFS_IRQ_ENABLE, (ch == 0) ? 32'h0000_0001 : 32'h0000_0000);
      wr32(ch ? `PCRAI_OFS_TGT_B_SEC : `PCRAI_OFS_TGT_A_SEC, 32'h0000_0007);
      wr32(ch ? `PCRAI_OFS_TGT_B_NS : `PCRAI_OFS_TGT_A_NS, 32'h0000_0320);
      repeat (60) @(posedge clk);
      rd32(`PCRAI_OFS_IRQ_STATUS, 32'h0000_0000);
      repeat (30) @(posedge clk);
      rd32(`PCRAI_OFS_IRQ_STATUS, 32'h0000_0001 << ch);
      @(negedge clk);
      chk({31'h0000_0000, ev}, {31'h0000_0000, ch == 0});
      chk({31'h0000_0000, irq}, {31'h0000_0000, ch == 0});
      gen <= 1'b0;
      @(negedge clk);
      chk({31'h0000_0000, irq}, 32'h0000_0000);
      @(posedge clk);
      wr32(`PCRAI_OFS_IRQ_STATUS, ~(32'h0000_0001 << ch));
      rd32(`PCRAI_OFS_IRQ_STATUS, 32'h0000_0001 << ch);
      if (ch == 1) begin
        // Both channels clear on a rising edge of GPIO 3.
        wr32(`PCRAI_OFS_CLR_CTL, 32'h0000_1B1B);
        gpio <= 8'h08;
        @(posedge clk);
        gpio <= 8'h00;
        repeat (4) @(posedge clk);
        rd32(`PCRAI_OFS_IRQ_STATUS, 32'h0000_0002);
        gpio <= 8'h08;
        repeat (3) @(posedge clk);
        gpio <= 8'h00;
        repeat (5) @(posedge clk);
        rd32(`PCRAI_OFS_IRQ_STATUS, 32'h0808_0000);
      end
      wr32(`PCRAI_OFS_IRQ_STATUS, 32'hFFFF_FFFF);
      rd32(`PCRAI_OFS_IRQ_STATUS, 32'h0000_0000);
      wr32(ch ? `PCRAI_OFS_TGT_B_SEC : `PCRAI_OFS_TGT_A_SEC, 32'hFFFF_FFFF);
    end
    $display("test end: timer flags");
    repeat (6) begin
      v = $random(seed) & `PCRAI_MSK_IRQ;
      pi = 3'($random(seed));
      pe = 3'($random(seed));
      wr32(`PCRAI_OFS_IRQ_ENABLE, v);
      ing <= pi;
      egr <= pe;
      gen <= 1'($random(seed));
      @(posedge clk);
      ing <= 3'h0;
      egr <= 3'h0;
      ex = {17'h0_0000, pe, 1'b0, pi, 8'h00};
      repeat (3) @(posedge clk);
      rd32(`PCRAI_OFS_IRQ_STATUS, ex);
      @(negedge clk);
      chk({31'h0000_0000, ev}, {31'h0000_0000, |(ex & v)});
      chk({31'h0000_0000, irq}, {31'h0000_0000, gen & |(ex & v)});
      @(posedge clk);
      wr32(`PCRAI_OFS_IRQ_STATUS, ex);
      rd32(`PCRAI_OFS_IRQ_STATUS, 32'h0000_0000);
    end
    $display("test end: stamp events");
    test_done();
  end

  // The full sequence needs well under two thousand cycles.
  initial begin
    repeat (6000) @(posedge clk);
    errors++;
    $display("[ERR] %0t watchdog expired", $time);
    test_done();
  end
endmodule
`default_nettype wire
